//--- serial_keyboard_controller_tb_top.sv
// Self-checking bench for the keyboard controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module serial_keyboard_controller_tb_top;
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 xlate_en = 1'b0;
  logic                 host_wr = 1'b0;
  logic                 host_rd = 1'b0;
  logic                 ack_en = 1'b1;
  logic [7:0]           host_wdata = 8'h00;
  logic [7:0]           host_rdata;
  logic [7:0]           b;
  skc_pkg::skc_status_t status;
  logic                 irq;
  logic                 clk_oe;
  logic                 dat_oe;
  logic                 clk_o;
  logic                 dat_o;
  logic                 kb_oe;
  logic                 ack_seen;
  logic [7:0]           rx_byte;
  logic                 rx_par;
  int                   rx_cnt;
  int                   failures = 0;
  int                   tests_run = 0;
  int                   seed = 32'h5976;
  // Pull-ups: a released line reads high
  wire                  clk_ln = clk_oe ? clk_o : 1'b1;
  wire                  dat_ln = (dat_oe ? dat_o : 1'b1) & ~kb_oe;
  always #2 clk = ~clk;
  skc_ctrl #(.HALF_CYC(4)) i_skc_ctrl (
    .clk(clk), .nrst(nrst), .xlate_en(xlate_en), .host_wr(host_wr),
    .host_wdata(host_wdata), .host_rd(host_rd), .host_rdata(host_rdata),
    .status(status), .irq(irq), .kbd_clk_i(clk_ln), .kbd_clk_o(clk_o),
    .kbd_clk_oe(clk_oe), .kbd_dat_i(dat_ln), .kbd_dat_o(dat_o),
    .kbd_dat_oe(dat_oe));
  skc_kbd_model i_skc_kbd_model (
    .clk_ln(clk_ln), .dat_ln(dat_ln), .ack_en(ack_en), .dat_oe(kb_oe),
    .ack_seen(ack_seen), .rx_byte(rx_byte), .rx_par(rx_par),
    .rx_cnt(rx_cnt));
  // Expected buffer byte: a pending prefix sets the top bit
  function automatic logic [7:0] xl_exp(input logic [7:0] c,
                                        input logic       brk);
    return brk ? (c | skc_pkg::BREAK_FLAG) : c;
  endfunction : xl_exp
  task automatic wait_st(input int i, input logic v);
    int n;
    n = 0;
    while (status[i] !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    `CHK("status bit", v, status[i])
  endtask : wait_st
  // Pulse host_rd, then check all flags dropped
  task automatic rd();
    @(posedge clk);
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("status", 4'h0, status)
    `CHK("irq", 1'b0, irq)
  endtask : rd
  task automatic kb_byte(input logic [7:0] v, input logic [7:0] e);
    i_skc_kbd_model.send(v, 1'b0);
    `CHK("ack", 1'b1, ack_seen)
    wait_st(0, 1'b1);
    `CHK("rdata", e, host_rdata)
    `CHK("irq", 1'b1, irq)
    rd();
  endtask : kb_byte
  // Second write lands mid-frame and must be dropped
  task automatic host_send(input logic [7:0] v);
    @(posedge clk);
    host_wr <= 1'b1;
    host_wdata <= v;
    @(posedge clk);
    host_wr <= 1'b0;
    repeat (10) @(posedge clk);
    host_wr <= 1'b1;
    host_wdata <= ~v;
    @(posedge clk);
    host_wr <= 1'b0;
    wait_st(1, 1'b0);
    repeat (4) @(posedge clk);
  endtask : host_send
  task automatic test_done();
    $display("tests %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK("status", 4'h0, status)
    for (int i = 0; i < 6; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      if (b == 8'hf0) b = 8'h0f;
      kb_byte(b, xl_exp(b, 1'b0));
    end
    i_skc_kbd_model.send(8'h5a, 1'b1);
    wait_st(2, 1'b1);
    `CHK("bad load", 1'b0, status.out_full)
    rd();
    xlate_en <= 1'b1;
    i_skc_kbd_model.send(skc_pkg::BREAK_PREFIX, 1'b0);
    repeat (8) @(posedge clk);
    `CHK("prefix load", 1'b0, status.out_full)
    kb_byte(8'h1c, xl_exp(8'h1c, 1'b1));
    for (int i = 0; i < 4; i++) begin
      b = (i == 0) ? 8'h00 : 8'($random(seed));
      host_send(b);
      `CHK("link byte", b, rx_byte)
      `CHK("link parity", 1'b1, rx_par)
      `CHK("link count", i + 1, rx_cnt)
      `CHK("ack byte", skc_pkg::ACK_BYTE, host_rdata)
      `CHK("irq", 1'b1, irq)
      rd();
    end
    ack_en <= 1'b0;
    host_send(8'h3c);
    `CHK("no ack", 1'b1, status.no_ack)
    `CHK("full", 1'b0, status.out_full)
    rd();
    test_done();
  end
endmodule : serial_keyboard_controller_tb_top
`default_nettype wire

//--- skc_ctrl.sv
// Keyboard controller: host byte port and open-drain serial link engine
`timescale 1ns/1ps
`default_nettype none
module skc_ctrl #(
  parameter int unsigned HALF_CYC = skc_pkg::HALF_CYC
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               xlate_en,
  input  wire logic               host_wr,
  input  wire logic [7:0]         host_wdata,
  input  wire logic               host_rd,
  output logic [7:0]              host_rdata,
  output skc_pkg::skc_status_t    status,
  output logic                    irq,
  input  wire logic               kbd_clk_i,
  output logic                    kbd_clk_o,
  output logic                    kbd_clk_oe,
  input  wire logic               kbd_dat_i,
  output logic                    kbd_dat_o,
  output logic                    kbd_dat_oe
);

  localparam logic [skc_pkg::CNT_W-1:0] RELOAD =
    skc_pkg::CNT_W'(HALF_CYC - 1);

  skc_pkg::skc_state_t               state_q, state_d;
  logic [skc_pkg::CNT_W-1:0]         cnt_q, cnt_d;
  logic                              low_q, low_d;
  logic [3:0]                        slot_q, slot_d;
  logic [skc_pkg::FRAME_W-1:0]       frame_q, frame_d;
  logic [7:0]                        tx_byte_q, tx_byte_d;
  logic [7:0]                        rdata_d;
  skc_pkg::skc_status_t              stat_d;
  logic                              clk_oe_d, dat_oe_d;
  skc_pkg::skc_byte_t                rx_push_q, rx_push_d;
  skc_pkg::skc_byte_t                xl_out;
  logic                              tick, rx_bad, ack_load;

  // Link clock line is unused as input: this end makes the clock
  logic unused_clk_in;
  assign unused_clk_in = kbd_clk_i;

  skc_xlate u_xlate (
    .clk      (clk),
    .nrst     (nrst),
    .en       (xlate_en),
    .in_byte  (rx_push_q),
    .out_byte (xl_out)
  );

  assign tick   = (cnt_q == '0);
  assign rx_bad = (~^frame_q[skc_pkg::PAR_POS:1])
                | ~frame_q[skc_pkg::STOP_POS];

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    low_d     = low_q;
    slot_d    = slot_q;
    frame_d   = frame_q;
    tx_byte_d = tx_byte_q;
    rdata_d   = host_rdata;
    stat_d    = status;
    dat_oe_d  = kbd_dat_oe;
    rx_push_d = skc_pkg::BYTE_NONE;
    ack_load  = 1'b0;

    // Clears first, so any same-cycle set below wins
    // read clears full
    if (host_rd) begin
      stat_d.out_full = 1'b0;
      stat_d.par_err  = 1'b0;
      stat_d.no_ack   = 1'b0;
    end
    if (host_wr && !status.in_full) begin
      stat_d.in_full = 1'b1;
      tx_byte_d      = host_wdata;
    end

    if (state_q == skc_pkg::ST_IDLE) begin
      cnt_d  = RELOAD;
      low_d  = 1'b0;
      slot_d = '0;
      // Receive waits while the buffer is full: keyboard holds its start
      if (!kbd_dat_i && !status.out_full) begin
        state_d = skc_pkg::ST_RX;
      end else if (status.in_full && !status.out_full && kbd_dat_i) begin
        state_d  = skc_pkg::ST_TX;
        frame_d  = {1'b1, ~^tx_byte_q, tx_byte_q, 1'b0};
        dat_oe_d = 1'b1;
      end
    end else begin
      cnt_d = tick ? RELOAD : cnt_q - 1'b1;
      if (tick) begin
        low_d = ~low_q;
        // End of low half: sample, then move to next slot
        if (low_q) begin
          slot_d = slot_q + 1'b1;
          case (state_q)
            skc_pkg::ST_RX: begin
              frame_d = {kbd_dat_i, frame_q[skc_pkg::FRAME_W-1:1]};
              if (slot_q == skc_pkg::SLOT_STOP) begin
                state_d  = skc_pkg::ST_RXACK;
                dat_oe_d = 1'b1;
              end
            end
            skc_pkg::ST_RXACK: begin
              state_d  = skc_pkg::ST_IDLE;
              dat_oe_d = 1'b0;
              if (rx_bad) begin
                stat_d.par_err = 1'b1;
              end else begin
                rx_push_d = '{1'b1, frame_q[8:1]};
              end
            end
            skc_pkg::ST_TX: begin
              frame_d = {1'b1, frame_q[skc_pkg::FRAME_W-1:1]};
              if (slot_q == skc_pkg::SLOT_STOP) begin
                state_d  = skc_pkg::ST_TXACK;
                dat_oe_d = 1'b0;
              end else begin
                dat_oe_d = ~frame_q[1];
              end
            end
            skc_pkg::ST_TXACK: begin
              state_d        = skc_pkg::ST_IDLE;
              stat_d.in_full = 1'b0;
              if (!kbd_dat_i) begin
                ack_load = 1'b1;
              end else begin
                stat_d.no_ack = 1'b1;
              end
            end
            default: state_d = skc_pkg::ST_IDLE;
          endcase
        end
      end
    end

    if (ack_load) begin
      stat_d.out_full = 1'b1;
      rdata_d         = skc_pkg::ACK_BYTE;
    end else if (xl_out.valid) begin
      stat_d.out_full = 1'b1;
      rdata_d         = xl_out.data;
    end

    clk_oe_d = low_d && (state_d != skc_pkg::ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q    <= skc_pkg::ST_IDLE;
      cnt_q      <= '0;
      low_q      <= 1'b0;
      slot_q     <= '0;
      frame_q    <= '0;
      tx_byte_q  <= skc_pkg::BYTE_RST;
      host_rdata <= skc_pkg::BYTE_RST;
      status     <= skc_pkg::STATUS_RST;
      irq        <= 1'b0;
      kbd_clk_oe <= 1'b0;
      kbd_dat_oe <= 1'b0;
      kbd_clk_o  <= 1'b0;
      kbd_dat_o  <= 1'b0;
      rx_push_q  <= skc_pkg::BYTE_NONE;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      low_q      <= low_d;
      slot_q     <= slot_d;
      frame_q    <= frame_d;
      tx_byte_q  <= tx_byte_d;
      host_rdata <= rdata_d;
      status     <= stat_d;
      irq        <= stat_d.out_full;
      kbd_clk_oe <= clk_oe_d;
      kbd_dat_oe <= dat_oe_d;
      // Open drain: only ever pulls low
      kbd_clk_o  <= 1'b0;
      kbd_dat_o  <= 1'b0;
      rx_push_q  <= rx_push_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic rx_done;
  assign rx_done = (state_q == skc_pkg::ST_RXACK) && tick && low_q;

  rx_parity_a: assert property (
    rx_done && rx_bad |=> status.par_err && !rx_push_q.valid)
    else $error("bad received frame not flagged");

  obf_load_a: assert property (
    xl_out.valid && !ack_load |=> status.out_full
      && host_rdata == $past(xl_out.data))
    else $error("translated byte not in output buffer");

  irq_follow_a: assert property (
    $rose(status.out_full) |-> $rose(irq))
    else $error("interrupt did not rise with buffer full");

  status_obf_a: assert property (
    irq == status.out_full)
    else $error("status full flag and interrupt disagree");

  obf_hold_a: assert property (
    status.out_full && !host_rd |=> status.out_full)
    else $error("buffer full flag dropped without a read");

  tx_accept_a: assert property (
    host_wr && !status.in_full |=> status.in_full
      && tx_byte_q == $past(host_wdata))
    else $error("host byte not taken for sending");

  tx_parity_a: assert property (
    state_q == skc_pkg::ST_TX |-> ^frame_q[skc_pkg::PAR_POS:1]
      || slot_q != 4'h0)
    else $error("sent frame lacks odd parity");

  rx_ack_a: assert property (
    state_q == skc_pkg::ST_RXACK && kbd_clk_oe |-> kbd_dat_oe)
    else $error("receive ack slot not driven low");

  tx_hold_a: assert property (
    state_q != skc_pkg::ST_IDLE && status.in_full |=> $stable(tx_byte_q))
    else $error("new byte taken while one is in flight");

  ack_irq_a: assert property (
    ack_load |=> irq && host_rdata == skc_pkg::ACK_BYTE)
    else $error("ack did not raise buffer-full interrupt");

  rd_clear_a: assert property (
    host_rd && !ack_load && !xl_out.valid |=> !status.out_full ##1 !irq
      || status.out_full)
    else $error("read did not clear buffer full");

  par_clear_a: assert property (
    host_rd && !(rx_done && rx_bad) |=> !status.par_err)
    else $error("error flag survived a read");

  rx_byte_c: cover property (xl_out.valid ##1 host_rd);
  tx_acked_c: cover property (ack_load);
  tx_noack_c: cover property ($rose(status.no_ack));
  rx_bad_c: cover property (rx_done && rx_bad);

endmodule : skc_ctrl
`default_nettype wire

//--- skc_kbd_model.sv
// Keyboard model for the far end of the serial link
`timescale 1ns/1ps
`default_nettype none
module skc_kbd_model (
  input  wire logic       clk_ln,
  input  wire logic       dat_ln,
  input  wire logic       ack_en,
  output logic            dat_oe,
  output logic            ack_seen,
  output logic [7:0]      rx_byte,
  output logic            rx_par,
  output int              rx_cnt
);
  logic [11:0] sh;
  int          k;
  logic        tx;
  initial begin
    dat_oe = 1'b0;
    ack_seen = 1'b0;
    rx_cnt = 0;
    k = 0;
    tx = 1'b0;
  end
  task automatic send(input logic [7:0] b, input logic bad);
    // Start off the controller's sampling edge to avoid a race
    #1;
    sh = {1'b0, 1'b1, (~^b) ^ bad, b, 1'b0};
    tx = 1'b1;
    dat_oe = 1'b1;
    for (int i = 0; i < 11; i++) begin
      @(negedge clk_ln);
      dat_oe = ~sh[i];
    end
    @(negedge clk_ln);
    #8;
    ack_seen = ~dat_ln;
    @(posedge clk_ln);
    tx = 1'b0;
  endtask : send
  always @(negedge clk_ln) begin
    if (!tx) begin
      sh[k] = dat_ln;
      k++;
    end
  end
  // ack each byte while ack_en is set, released after slot
  always @(posedge clk_ln) begin
    if (!tx && k == 11) begin
      dat_oe = ack_en;
    end else if (!tx && k == 12) begin
      dat_oe = 1'b0;
      rx_byte = sh[8:1];
      rx_par = ^sh[9:1];
      rx_cnt++;
      k = 0;
    end
  end
endmodule : skc_kbd_model
`default_nettype wire

//--- skc_pkg.sv
// Shared constants and types for the serial keyboard controller
package skc_pkg;

  // Link timing: half of one bit cell on the keyboard link
  localparam int          CLK_NS   = 4;
  localparam int          HALF_NS  = 50000;
  localparam int          HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W    = 16;

  // Frame layout: start, 8 data LSB first, odd parity, stop, ack slot
  localparam int          FRAME_W    = 11;
  localparam logic [3:0]  SLOT_STOP  = 4'ha;
  localparam int          PAR_POS    = 9;
  localparam int          STOP_POS   = 10;

  // Byte placed in the output buffer when a sent byte is acknowledged
  localparam logic [7:0]  ACK_BYTE     = 8'hfa;
  // Scan-code prefix folded into the following code as its top bit
  localparam logic [7:0]  BREAK_PREFIX = 8'hf0;
  localparam logic [7:0]  BREAK_FLAG   = 8'h80;
  localparam logic [7:0]  BYTE_RST     = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RX    = 3'h1,
    ST_TX    = 3'h3,
    ST_TXACK = 3'h2,
    ST_RXACK = 3'h6
  } skc_state_t;

  typedef struct packed {
    logic no_ack;
    logic par_err;
    logic in_full;
    logic out_full;
  } skc_status_t;

  localparam skc_status_t STATUS_RST = '{1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } skc_byte_t;

  localparam skc_byte_t BYTE_NONE = '{1'b0, 8'h00};

endpackage : skc_pkg

//--- skc_xlate.sv
// Scan-code translation stage between the receiver and the output buffer
`timescale 1ns/1ps
`default_nettype none
module skc_xlate (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              en,
  input  wire skc_pkg::skc_byte_t in_byte,
  output var  skc_pkg::skc_byte_t out_byte
);

  logic               brk_q;
  logic               brk_d;
  skc_pkg::skc_byte_t out_d;

  always_comb begin
    brk_d = brk_q & en;
    out_d = skc_pkg::BYTE_NONE;
    if (in_byte.valid) begin
      // Prefix is swallowed; the next code carries it as its top bit
      if (en && in_byte.data == skc_pkg::BREAK_PREFIX) begin
        brk_d = 1'b1;
      end else begin
        out_d.valid = 1'b1;
        out_d.data  = (en && brk_q) ? (in_byte.data | skc_pkg::BREAK_FLAG)
                                    : in_byte.data;
        brk_d       = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      brk_q    <= 1'b0;
      out_byte <= skc_pkg::BYTE_NONE;
    end else begin
      brk_q    <= brk_d;
      out_byte <= out_d;
    end
  end

endmodule : skc_xlate
`default_nettype wire
